// [pkg/pfc_fault_if.sv]
// signals between the register side and the fault latch core
// assumes one clock domain; all signals are levels except ack, a one-cycle pulse
`timescale 1ns/1ps
interface pfc_fault_if;
    logic [7:0] ctrl;
    logic [3:0] ack;
    logic [3:0] flags;
    logic [3:0] pins;
    logic [3:0] shutdown;
    modport regs (output ctrl, output ack, input flags, input pins, input shutdown);
    modport core (input ctrl, input ack, output flags, output pins, output shutdown);
endinterface

// [pkg/pfc_pkg.sv]
// package of the fault control block: register map, field positions, reset values
// assumes a 32-bit AXI4-Lite register bus and four filtered trip inputs
package pfc_pkg;
    localparam int TRIP_N = 4;
    localparam int PWM_N = 4;
    localparam int AXI_AW = 12;
    // printed register index; byte address is four times it
    localparam logic [AXI_AW-1:0] FCTRL_LOW_IDX = 12'h042;
    localparam logic [AXI_AW-1:0] FCTRL_LOW_ADDR = 12'h108;
    localparam logic [AXI_AW-1:0] FSTATUS_ADDR = 12'h10c;
    localparam logic [AXI_AW-1:0] DISMAP_ADDR = 12'h110;
    localparam logic [AXI_AW-1:0] IRQ_MASK_ADDR = 12'h114;
    // fault_control_low field positions
    localparam int TRIP0_CLEAR_SELECT_POS = 0;
    localparam int TRIP0_IRQ_ENABLE_POS = 1;
    localparam int TRIP1_CLEAR_SELECT_POS = 2;
    localparam int TRIP1_IRQ_ENABLE_POS = 3;
    localparam int TRIP2_CLEAR_SELECT_POS = 4;
    localparam int TRIP2_IRQ_ENABLE_POS = 5;
    localparam int TRIP3_CLEAR_SELECT_POS = 6;
    localparam int TRIP3_IRQ_ENABLE_POS = 7;
    // fault status fields: latched flags low, filtered pin levels high
    localparam int FSTATUS_FLAG_POS = 0;
    localparam int FSTATUS_PIN_POS = 4;
    // reset values
    localparam logic [7:0] FCTRL_LOW_RST = 8'h00;
    localparam logic [15:0] DISMAP_RST = 16'hffff;
    localparam logic [3:0] IRQ_MASK_RST = 4'hf;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // flag set latency bound, in clock cycles
    localparam int FLAG_SET_MAX_CYC = 2;

    typedef enum logic [2:0] {
        PFC_SEL_NONE = 3'b000,
        PFC_SEL_FCTRL = 3'b001,
        PFC_SEL_FSTATUS = 3'b010,
        PFC_SEL_DISMAP = 3'b011,
        PFC_SEL_MASK = 3'b100
    } pfc_sel_t;

    typedef enum logic [0:0] {
        PFC_WR_COLLECT = 1'b0,
        PFC_WR_RESP = 1'b1
    } pfc_wr_state_t;

    typedef enum logic [0:0] {
        PFC_RD_IDLE = 1'b0,
        PFC_RD_RESP = 1'b1
    } pfc_rd_state_t;
endpackage

// [src/pfc_fault_core.sv]
// fault latch core: edge detect, sticky flags, shutdown per trip input
// assumes trip inputs already filtered and synchronous to clock
`timescale 1ns/1ps
module pfc_fault_core (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filtered trip inputs, high means fault
    input wire logic [pfc_pkg::TRIP_N-1:0] trip_in,
    // register side
    pfc_fault_if.core fif
);
    import pfc_pkg::*;

    logic [3:0] pin_r;
    logic [3:0] pin_nxt;
    logic [3:0] flag_r;
    logic [3:0] flag_nxt;
    logic [3:0] shut_r;
    logic [3:0] shut_nxt;

    // next flags, pin history and shutdown
    always_comb begin
        pin_nxt = trip_in;
        flag_nxt = flag_r;
        shut_nxt = shut_r;
        for (int n = 0; n < TRIP_N; n++) begin
            // latched regardless of pwm enable or irq enable
            if (fif.ack[n]) begin
                flag_nxt[n] = 1'b0;
            end
            if (trip_in[n] && !pin_r[n]) begin
                flag_nxt[n] = 1'b1;
            end
            // clear select: 1 auto follows pin, 0 manual holds till flag cleared
            if (fif.ctrl[2*n]) begin
                shut_nxt[n] = trip_in[n];
            end else begin
                shut_nxt[n] = flag_nxt[n] | (trip_in[n] & ~pin_r[n]);
            end
        end
    end

    // state registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= 4'h0;
            flag_r <= 4'h0;
            shut_r <= 4'h0;
        end else begin
            pin_r <= pin_nxt;
            flag_r <= flag_nxt;
            shut_r <= shut_nxt;
        end
    end

    // outward view
    assign fif.flags = flag_r;
    assign fif.pins = pin_r;
    assign fif.shutdown = shut_r;
endmodule

// [src/pfc_fault_ctrl.sv]
// PWM fault control: AXI4-Lite registers, fault interrupt, output shutdown
// assumes filtered trip inputs and pwm drive levels synchronous to clock
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pfc_fault_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pfc_pkg::AXI_AW-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [pfc_pkg::AXI_AW-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // filtered trip inputs and pwm outputs
    input wire logic [pfc_pkg::TRIP_N-1:0] trip_in,
    input wire logic [pfc_pkg::PWM_N-1:0] pwm_in,
    output logic [pfc_pkg::PWM_N-1:0] pwm_out,
    // interrupt
    output logic fault_irq
);
    import pfc_pkg::*;

    // address decode shared by read and write
    function automatic pfc_sel_t reg_sel(input logic [AXI_AW-1:0] addr);
        case (addr)
            FCTRL_LOW_ADDR: reg_sel = PFC_SEL_FCTRL;
            FSTATUS_ADDR: reg_sel = PFC_SEL_FSTATUS;
            DISMAP_ADDR: reg_sel = PFC_SEL_DISMAP;
            IRQ_MASK_ADDR: reg_sel = PFC_SEL_MASK;
            default: reg_sel = PFC_SEL_NONE;
        endcase
    endfunction

    pfc_fault_if fif ();

    pfc_wr_state_t wr_state_r;
    pfc_wr_state_t wr_state_nxt;
    logic aw_have_r;
    logic aw_have_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [AXI_AW-1:0] waddr_r;
    logic [AXI_AW-1:0] waddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic [7:0] fctrl_r;
    logic [7:0] fctrl_nxt;
    logic [15:0] dismap_r;
    logic [15:0] dismap_nxt;
    logic [3:0] mask_r;
    logic [3:0] mask_nxt;
    logic [3:0] ack_r;
    logic [3:0] ack_nxt;
    pfc_sel_t wsel;

    pfc_rd_state_t rd_state_r;
    pfc_rd_state_t rd_state_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    pfc_sel_t rsel;

    logic irq_r;
    logic irq_nxt;
    logic [PWM_N-1:0] pwm_r;
    logic [PWM_N-1:0] pwm_nxt;
    logic [3:0] irq_en;

    pfc_fault_core u_core (
        .clock(clock),
        .rst_n(rst_n),
        .trip_in(trip_in),
        .fif(fif)
    );

    assign fif.ctrl = fctrl_r;
    assign fif.ack = ack_r;
    assign wsel = reg_sel(waddr_r);

    // write channel: collect address and data in any order, then answer
    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        fctrl_nxt = fctrl_r;
        dismap_nxt = dismap_r;
        mask_nxt = mask_r;
        ack_nxt = 4'h0;
        case (wr_state_r)
            PFC_WR_COLLECT: begin
                if (s_axi_awvalid && awready_r) begin
                    aw_have_nxt = 1'b1;
                    waddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_r) begin
                    w_have_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (aw_have_r && w_have_r) begin
                    aw_have_nxt = 1'b0;
                    w_have_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    bresp_nxt = RESP_OKAY;
                    wr_state_nxt = PFC_WR_RESP;
                    case (wsel)
                        PFC_SEL_FCTRL: begin
                            if (wstrb_r[0]) begin
                                fctrl_nxt = wdata_r[7:0];
                            end
                        end
                        PFC_SEL_FSTATUS: begin
                            // ones acknowledge, zeros are ignored
                            if (wstrb_r[0]) begin
                                ack_nxt = wdata_r[FSTATUS_FLAG_POS +: 4];
                            end
                        end
                        PFC_SEL_DISMAP: begin
                            if (wstrb_r[0]) begin
                                dismap_nxt[7:0] = wdata_r[7:0];
                            end
                            if (wstrb_r[1]) begin
                                dismap_nxt[15:8] = wdata_r[15:8];
                            end
                        end
                        PFC_SEL_MASK: begin
                            if (wstrb_r[0]) begin
                                mask_nxt = wdata_r[3:0];
                            end
                        end
                        default: begin
                            bresp_nxt = RESP_SLVERR;
                        end
                    endcase
                end
            end
            PFC_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_nxt = 1'b0;
                    wr_state_nxt = PFC_WR_COLLECT;
                end
            end
            default: begin
                wr_state_nxt = PFC_WR_COLLECT;
            end
        endcase
        awready_nxt = (wr_state_nxt == PFC_WR_COLLECT) && !aw_have_nxt;
        wready_nxt = (wr_state_nxt == PFC_WR_COLLECT) && !w_have_nxt;
    end

    // write channel registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_r <= PFC_WR_COLLECT;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            fctrl_r <= FCTRL_LOW_RST;
            dismap_r <= DISMAP_RST;
            mask_r <= IRQ_MASK_RST;
            ack_r <= 4'h0;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            fctrl_r <= fctrl_nxt;
            dismap_r <= dismap_nxt;
            mask_r <= mask_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign rsel = reg_sel(s_axi_araddr);

    // read channel: one cycle from address taken to data valid
    always_comb begin
        rd_state_nxt = rd_state_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rd_state_r)
            PFC_RD_IDLE: begin
                if (s_axi_arvalid && arready_r) begin
                    rvalid_nxt = 1'b1;
                    rresp_nxt = RESP_OKAY;
                    rdata_nxt = 32'h0;
                    rd_state_nxt = PFC_RD_RESP;
                    case (rsel)
                        PFC_SEL_FCTRL: rdata_nxt[7:0] = fctrl_r;
                        PFC_SEL_FSTATUS: begin
                            rdata_nxt[FSTATUS_FLAG_POS +: 4] = fif.flags;
                            rdata_nxt[FSTATUS_PIN_POS +: 4] = fif.pins;
                        end
                        PFC_SEL_DISMAP: rdata_nxt[15:0] = dismap_r;
                        PFC_SEL_MASK: rdata_nxt[3:0] = mask_r;
                        default: rresp_nxt = RESP_SLVERR;
                    endcase
                end
            end
            PFC_RD_RESP: begin
                if (s_axi_rready) begin
                    rvalid_nxt = 1'b0;
                    rd_state_nxt = PFC_RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = PFC_RD_IDLE;
            end
        endcase
        arready_nxt = (rd_state_nxt == PFC_RD_IDLE);
    end

    // read channel registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_r <= PFC_RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // per-input irq enables from the control register
    assign irq_en[3] = fctrl_r[TRIP3_IRQ_ENABLE_POS];
    assign irq_en[2] = fctrl_r[TRIP2_IRQ_ENABLE_POS];
    assign irq_en[1] = fctrl_r[TRIP1_IRQ_ENABLE_POS];
    assign irq_en[0] = fctrl_r[TRIP0_IRQ_ENABLE_POS];

    // interrupt and output shutdown; shutdown never looks at irq_en
    always_comb begin
        irq_nxt = |(fif.flags & irq_en & mask_r);
        for (int k = 0; k < PWM_N; k++) begin
            pwm_nxt[k] = pwm_in[k];
            for (int n = 0; n < TRIP_N; n++) begin
                if (fif.shutdown[n] && dismap_r[n*PWM_N + k]) begin
                    pwm_nxt[k] = 1'b0;
                end
            end
        end
    end

    // output registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
            pwm_r <= '0;
        end else begin
            irq_r <= irq_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pwm_out = pwm_r;
    assign fault_irq = irq_r;
endmodule

// [verification/pfc_fault_ctrl_assertions.sv]
// checker of the fault control block, bound to its top module
// assumes the disable map stays at its reset value, all outputs mapped to every trip
`timescale 1ns/1ps
module pfc_fault_ctrl_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // fault side
    input wire logic [3:0] trip_in,
    input wire logic [3:0] pwm_in,
    input wire logic [3:0] pwm_out,
    input wire logic fault_irq
);
    logic trip_seen_r;
    logic trip_seen_nxt;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // remembers any trip activity since reset
    always_comb trip_seen_nxt = trip_seen_r | (|trip_in);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trip_seen_r <= 1'b0;
        end else begin
            trip_seen_r <= trip_seen_nxt;
        end
    end
    a_pwm_only_forced: assert property ((pwm_out & ~$past(pwm_in)) == 4'h0)
        else $error("pwm output high without drive");
    a_trip_shuts_pwm: assert property (|(trip_in & ~$past(trip_in)) |-> ##[1:3] (pwm_out == 4'h0))
        else $error("trip rise did not shut pwm outputs");
    a_irq_has_cause: assert property ($rose(fault_irq) |-> trip_seen_r)
        else $error("interrupt without any trip");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !fault_irq && pwm_out == 4'h0)
        else $error("outputs active in reset");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

bind pfc_fault_ctrl pfc_fault_ctrl_assertions u_assert (
    .clock(clock), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .trip_in(trip_in), .pwm_in(pwm_in), .pwm_out(pwm_out), .fault_irq(fault_irq)
);

// [verification/pfc_trip_model.sv]
// power stage fault source: turns bench fault commands into filtered trip levels
// assumes commands change just after a rising clock edge
`timescale 1ns/1ps
module pfc_trip_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fault commands and answer speed
    input wire logic [3:0] fault_cmd,
    input wire logic slow,
    // filtered trip levels, high means fault
    output logic [3:0] trip_in
);
    logic [3:0] stage_r;
    // one stage of filter delay, a second one when slow
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= 4'h0;
            trip_in <= 4'h0;
        end else begin
            stage_r <= fault_cmd;
            trip_in <= slow ? stage_r : fault_cmd;
        end
    end
endmodule

// [verification/testbench.sv]
// testbench: drives the fault control block over axi4-lite and through the trip model
// assumes one 40 MHz clock and the register map of pfc_pkg
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module testbench;
    import pfc_pkg::*;
    logic clock = 0;
    logic rst_n = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
    logic awready, wready, bvalid, arready, rvalid, fault_irq;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] fault_cmd = 4'h0, pwm_in = 4'hf, trip_in, pwm_out;
    int fails = 0, checks_done = 0, hold_off = 0;
    // 40 MHz clock
    always #12.5 clock = ~clock;
    pfc_trip_model model (.clock(clock), .rst_n(rst_n), .fault_cmd(fault_cmd), .slow(slow), .trip_in(trip_in));
    pfc_fault_ctrl uut (
        .clock(clock), .rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .trip_in(trip_in), .pwm_in(pwm_in), .pwm_out(pwm_out),
        .fault_irq(fault_irq)
    );
    // verdict and end of run
    task automatic complete_run;
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic hang_out;
        `CHK("wait bound", 1'b0, 1'b1)
        complete_run();
    endtask
    // one write; address and data offered together, each released when taken
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (n >= hold_off) bready <= 1;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bready && bvalid) break;
        end
        resp = bresp;
        bready <= 0;
        if (n == 40) hang_out();
    endtask
    // one read
    task automatic rdr(input logic [AXI_AW-1:0] a);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (n >= hold_off) rready <= 1;
            if (arvalid && arready) arvalid <= 0;
            if (rready && rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 0;
        if (n == 40) hang_out();
    endtask
    task automatic chk_rd(input logic [AXI_AW-1:0] a, input logic [31:0] e, input string nm);
        rdr(a);
        `CHK(nm, e, rd)
        `CHK("rresp", RESP_OKAY, resp)
    endtask
    task automatic drive(input logic [3:0] v);
        @(posedge clock);
        fault_cmd <= v;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clock);
    endtask
    // bounded wait for the interrupt level
    task automatic see_irq(input logic e);
        int n;
        for (n = 0; n < 8 && fault_irq !== e; n++) @(posedge clock);
        `CHK("fault_irq", e, fault_irq)
        if (fault_irq !== e) complete_run();
    endtask
    // raise one trip, see shutdown, drop it again
    task automatic pulse(input int t);
        drive(4'(1 << t));
        settle(6);
        `CHK("shutdown", 4'h0, pwm_out)
        drive(4'h0);
        settle(6);
    endtask
    // reset values, unmapped accesses with a lazy master
    task automatic s_reset;
        chk_rd(FCTRL_LOW_ADDR, FCTRL_LOW_RST, "ctrl");
        chk_rd(DISMAP_ADDR, DISMAP_RST, "dismap");
        wr(DISMAP_ADDR, 32'h1234);
        `CHK("dismap wr resp", RESP_OKAY, resp)
        chk_rd(DISMAP_ADDR, 32'h1234, "dismap write");
        wr(DISMAP_ADDR, {16'h0, DISMAP_RST});
        chk_rd(DISMAP_ADDR, {16'h0, DISMAP_RST}, "dismap restore");
        chk_rd(IRQ_MASK_ADDR, IRQ_MASK_RST, "mask");
        chk_rd(FSTATUS_ADDR, 32'h0, "status");
        hold_off = 3;
        rdr(12'h000);
        `CHK("bad rd resp", RESP_SLVERR, resp)
        wr(12'h000, 32'hff);
        `CHK("bad wr resp", RESP_SLVERR, resp)
        hold_off = 0;
        `CHK("irq idle", 1'b0, fault_irq)
    endtask
    // interrupt enable gating per trip, mask and acknowledge
    task automatic s_irq_gate;
        for (int t = 0; t < 4; t++) begin
            wr(FSTATUS_ADDR, 32'hf);
            wr(FCTRL_LOW_ADDR, 32'h1 << (2 * t + 1));
            chk_rd(FCTRL_LOW_ADDR, 32'h1 << (2 * t + 1), "ctrl readback");
            drive(4'(1 << ((t + 1) % 4)));
            settle(6);
            `CHK("irq blocked", 1'b0, fault_irq)
            `CHK("pwm shut", 4'h0, pwm_out)
            drive(4'(1 << t));
            see_irq(1'b1);
            wr(IRQ_MASK_ADDR, 32'h0);
            see_irq(1'b0);
            wr(IRQ_MASK_ADDR, 32'hf);
            drive(4'h0);
            settle(4);
            `CHK("manual hold", 4'h0, pwm_out)
            wr(FSTATUS_ADDR, 32'hf);
            see_irq(1'b0);
            settle(3);
            `CHK("pwm back", 4'hf, pwm_out)
        end
    endtask
    // automatic and manual clearing per trip, slow trip source
    task automatic s_modes;
        for (int t = 0; t < 4; t++) begin
            wr(FCTRL_LOW_ADDR, 32'h1 << (2 * t));
            pulse(t);
            `CHK("auto release", pwm_in, pwm_out)
            chk_rd(FSTATUS_ADDR, 32'h1 << t, "flag kept");
            wr(FSTATUS_ADDR, 32'h0);
            chk_rd(FSTATUS_ADDR, 32'h1 << t, "flag after zero");
            wr(FSTATUS_ADDR, 32'h1 << t);
            wr(FCTRL_LOW_ADDR, 32'h0);
            pulse(t);
            `CHK("manual hold", 4'h0, pwm_out)
            wr(FSTATUS_ADDR, 32'h1 << t);
            settle(3);
            `CHK("manual release", pwm_in, pwm_out)
        end
    endtask
    // main sequence
    initial begin
        // falling edge at time zero so every async reset branch runs
        rst_n <= 0;
        repeat (4) @(posedge clock);
        rst_n <= 1;
        settle(2);
        s_reset();
        s_irq_gate();
        slow <= 1;
        pwm_in <= 4'h5;
        s_modes();
        complete_run();
    end
endmodule
